// ### logic/dcd_decoder.sv
/*
 command decoder: takes host bytes, tracks parameter sequences and holds the
 configuration settings and gray tables.

 byte path
   a byte counts only when byte_strobe is high and chip_select_n is low.
   data_select low marks a command code, high marks a parameter byte.
   the command code is kept in cmd_reg so that later parameter bytes
   know which setting they belong to.
   a new command always restarts the sequencer, so a host that stops
   half way through a parameter list loses nothing but that list.

 sequencer states
   idle : nothing taken since reset; parameter bytes are dropped.
   one  : a single-parameter command waits for its byte.
   gray : the gray table command collects up to fifteen bytes.
   enh2 : the second byte of enhancement b, which is fixed and dropped.
   skip : parameters of unknown, finished or refused commands are dropped.

 settings
   precharge level      5 bits, upper bits of the byte are dont-care.
   deselect level       3 bits, upper bits of the byte are dont-care.
   segment current      full byte, every code is legal.
   master current       4 bits, scales all currents to (n+1)/16.
   mux ratio            7 bits, values below the floor are refused and
                        the old ratio stays in force.
   enhancement b mode   bits five and four of the first byte; the
                        reserved code is refused and the old mode stays.
   lock                 bit two of the lock parameter.

 lock behaviour
   while locked every command but the lock command is refused, and so
   are the parameters of refused commands.  a refused command still
   sends the sequencer to skip, so that stray parameters that follow it
   cannot land on the setting of an older command.
   the memory access flag is the inverse of the lock, one cycle late.

 gray tables
   the loaded table collects bytes for levels one to fifteen.
   nothing reaches the active table until the enable command, so a
   half-written table never shows on the output.
   the linear command rebuilds the active table from the step constant
   and also clears the custom flag.
   level zero of the active table is always zero.
   the loaded table is not cleared by the linear command, so a later
   enable brings the last loaded table back.

 outputs
   every output comes straight from a flip-flop.
   the width bus trails the active table by one cycle, so the widths
   show two cycles after the enable or linear command is taken.

 hazards and limits
   the host must keep gray widths increasing; the block stores what
   it is given and does not check the order.
   extra parameter bytes past the expected count are dropped.
   a byte taken in the same cycle as a command is impossible, since
   there is one strobe per byte.

 assumes byte_strobe is a one-cycle pulse per host byte, synchronous to core_clk.
 assumes reset is asynchronous, active high, and held for at least one edge.
 assumes the host drives the bus only from the core clock domain.
*/
`timescale 1ns/1ns
module dcd_decoder
   import dcd_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        chip_select_n,
   input  wire logic        data_select,
   input  wire logic        byte_strobe,
   input  wire logic [7:0]  byte_data,
   output logic [4:0]       precharge_level,
   output logic [2:0]       common_deselect_level,
   output logic [7:0]       segment_current,
   output logic [3:0]       master_current,
   output logic [6:0]       mux_ratio,
   output logic [1:0]       enhance_b_mode,
   output logic             locked,
   output logic             gray_custom_active,
   output logic             memory_access_ok,
   output logic [127:0]     gray_level_widths
);
   dcd_state_type state_reg;
   logic [7:0]    cmd_reg;
   logic [3:0]    gray_idx_reg;
   logic [7:0]    load_tab_reg [1:15];
   logic [7:0]    act_tab_reg  [0:15];

   // byte qualification: chip select gates, lock filters commands
   wire take      = byte_strobe && !chip_select_n;
   wire is_cmd    = take && !data_select;
   wire is_par    = take && data_select;
   wire cmd_ok    = is_cmd && (!locked || byte_data == CMD_LOCK);
   wire par_ok    = is_par && (!locked || cmd_reg == CMD_LOCK);
   wire one_par   = state_reg == ST_ONE && par_ok;
   wire gray_par  = state_reg == ST_GRAY && par_ok;
   wire mux_valid = byte_data[6:0] >= MUX_MIN;
   wire enh_valid = byte_data[ENH_B_LSB+1:ENH_B_LSB] != ENH_B_RESERVED;

   // next sequencer state for each accepted command
   // a refused command still moves to skip, which drops its parameters
   // the gray state counts bytes through gray_idx_reg and ends at level 15
   dcd_state_type state_next;
   always_comb begin
      state_next = state_reg;
      if (cmd_ok) begin
         unique case (byte_data)
            CMD_GRAY_TABLE: state_next = ST_GRAY;
            CMD_PRECHARGE, CMD_DESELECT, CMD_CONTRAST, CMD_MASTER_CUR,
            CMD_MUX_RATIO, CMD_ENHANCE_B, CMD_LOCK: state_next = ST_ONE;
            default: state_next = ST_SKIP;
         endcase
      end else if (is_cmd) begin
         state_next = ST_SKIP;                                 // ignored while locked
      end else if (par_ok) begin
         unique case (state_reg)
            ST_ONE:  state_next = (cmd_reg == CMD_ENHANCE_B) ? ST_ENH2 : ST_SKIP;
            ST_GRAY: state_next = (gray_idx_reg == GRAY_LAST) ? ST_SKIP : ST_GRAY;
            ST_ENH2: state_next = ST_SKIP;                      // second byte fixed
            default: state_next = state_reg;
         endcase
      end
   end

   // sequencer and command latch
   // the level index restarts at one on every accepted command
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_reg    <= ST_IDLE;
         cmd_reg      <= 8'h00;
         gray_idx_reg <= 4'h1;
      end else begin
         state_reg <= state_next;
         if (cmd_ok) begin
            cmd_reg      <= byte_data;
            gray_idx_reg <= 4'h1;
         end else if (gray_par) begin
            gray_idx_reg <= gray_idx_reg + 4'h1;
         end
      end
   end

   // single-parameter settings; don't-care bits are dropped
   // refused values leave the old setting in place
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         precharge_level       <= PRECHARGE_RESET;
         common_deselect_level <= DESELECT_RESET;
         segment_current       <= CONTRAST_RESET;
         master_current        <= MASTER_RESET;
         mux_ratio             <= MUX_RESET;
         enhance_b_mode        <= ENH_B_RESET;
         locked                <= 1'b0;
      end else if (one_par) begin
         unique case (cmd_reg)
            CMD_PRECHARGE:  precharge_level       <= byte_data[4:0];
            CMD_DESELECT:   common_deselect_level <= byte_data[2:0];
            CMD_CONTRAST:   segment_current       <= byte_data;
            CMD_MASTER_CUR: master_current        <= byte_data[3:0];
            CMD_MUX_RATIO:  if (mux_valid) mux_ratio <= byte_data[6:0];
            CMD_ENHANCE_B:  if (enh_valid) begin
               enhance_b_mode <= byte_data[ENH_B_LSB+1:ENH_B_LSB];
            end
            CMD_LOCK:       locked <= byte_data[LOCK_BIT];
            default:        locked <= locked;
         endcase
      end
   end

   // loaded table, and active table switched by enable or linear commands
   // the active table holds the linear form out of reset
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         gray_custom_active <= 1'b0;
         for (int i = 1; i < GRAY_LEVELS; i++) load_tab_reg[i] <= 8'h00;
         for (int i = 0; i < GRAY_LEVELS; i++) begin
            act_tab_reg[i] <= (i < 2) ? 8'h00 : 8'((i - 1) * 8);
         end
      end else begin
         if (gray_par) load_tab_reg[gray_idx_reg] <= byte_data;
         if (cmd_ok && byte_data == CMD_GRAY_ENABLE) begin
            gray_custom_active <= 1'b1;
            act_tab_reg[0] <= 8'h00;
            for (int i = 1; i < GRAY_LEVELS; i++) act_tab_reg[i] <= load_tab_reg[i];
         end else if (cmd_ok && byte_data == CMD_GRAY_LINEAR) begin
            gray_custom_active <= 1'b0;
            for (int i = 0; i < GRAY_LEVELS; i++) begin
               act_tab_reg[i] <= (i < 2) ? 8'h00 : 8'((i - 1)) * GRAY_STEP;
            end
         end
      end
   end

   // memory access gate: the inverse of the lock, registered one cycle late
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) memory_access_ok <= 1'b1;
      else       memory_access_ok <= !locked;
   end

   // flattened active table, level n in bits 8n+7:8n
   // cleared during reset, linear from the first edge after release
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) gray_level_widths <= '0;
      else for (int i = 0; i < GRAY_LEVELS; i++) gray_level_widths[i*8 +: 8] <= act_tab_reg[i];
   end
endmodule

// ### inc/dcd_pkg.sv
/*
 holds the command codes, parameter field positions, reset values and table
 constants of the display configuration command decoder.
 assumes one core clock and a host that writes whole bytes with a strobe.
*/
package dcd_pkg;
   localparam logic [7:0] CMD_GRAY_ENABLE  = 8'h00;
   localparam logic [7:0] CMD_GRAY_TABLE   = 8'hB8;
   localparam logic [7:0] CMD_GRAY_LINEAR  = 8'hB9;
   localparam logic [7:0] CMD_PRECHARGE    = 8'hBB;
   localparam logic [7:0] CMD_DESELECT     = 8'hBE;
   localparam logic [7:0] CMD_CONTRAST     = 8'hC1;
   localparam logic [7:0] CMD_MASTER_CUR   = 8'hC7;
   localparam logic [7:0] CMD_MUX_RATIO    = 8'hCA;
   localparam logic [7:0] CMD_ENHANCE_B    = 8'hD1;
   localparam logic [7:0] CMD_LOCK         = 8'hFD;

   localparam logic [4:0] PRECHARGE_RESET  = 5'h17;
   localparam logic [2:0] DESELECT_RESET   = 3'h4;
   localparam logic [7:0] CONTRAST_RESET   = 8'h7F;
   localparam logic [3:0] MASTER_RESET     = 4'hF;
   localparam logic [6:0] MUX_RESET        = 7'h7F;
   localparam logic [6:0] MUX_MIN          = 7'h0F;
   localparam logic [1:0] ENH_B_RESET      = 2'h2;
   localparam logic [1:0] ENH_B_RESERVED   = 2'h0;
   localparam logic [7:0] ENH_B_SECOND     = 8'h20;
   localparam int         ENH_B_LSB        = 4;
   localparam int         LOCK_BIT         = 2;

   localparam int         GRAY_LEVELS      = 16;
   localparam logic [3:0] GRAY_LAST        = 4'hF;
   localparam logic [7:0] GRAY_STEP        = 8'h08;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_ONE   = 5'b00010,
      ST_GRAY  = 5'b00100,
      ST_ENH2  = 5'b01000,
      ST_SKIP  = 5'b10000
   } dcd_state_type;
endpackage

// ### test/dcd_decoder_assertions.sv
/* port checker for the command decoder.
   assumes one core clock and an async active-high reset. */
`timescale 1ns/1ns
module dcd_checker
   import dcd_pkg::*;
(
   input wire logic         core_clk,
   input wire logic         reset,
   input wire logic         chip_select_n,
   input wire logic         data_select,
   input wire logic         byte_strobe,
   input wire logic [7:0]   byte_data,
   input wire logic [7:0]   segment_current,
   input wire logic [6:0]   mux_ratio,
   input wire logic [1:0]   enhance_b_mode,
   input wire logic         locked,
   input wire logic         gray_custom_active,
   input wire logic         memory_access_ok,
   input wire logic [127:0] gray_level_widths
);
   localparam logic [127:0] LIN = 128'h70686058_50484038_30282018_10080000;
   // byte acceptance and a snapshot of the settings
   wire        acc      = byte_strobe && !chip_select_n;
   wire        lock_bit = byte_data[LOCK_BIT];
   wire [18:0] cfg      = {segment_current, mux_ratio, enhance_b_mode, locked, gray_custom_active};
   default clocking dcb @(posedge core_clk); endclocking
   default disable iff (reset);
   // a command taken, then its first parameter
   sequence take(c);
      acc && !data_select && byte_data == c && (!locked || c == CMD_LOCK) ##1 acc && data_select;
   endsequence
   contrast_write_a: assert property (take(CMD_CONTRAST) |=> segment_current == $past(byte_data))
      else $error("contrast not stored");
   idle_bus_a: assert property (!acc |=> $stable(cfg))
      else $error("setting moved without a byte");
   mux_floor_a: assert property (mux_ratio >= MUX_MIN)
      else $error("mux ratio below floor");
   mux_reject_a: assert property (take(CMD_MUX_RATIO) ##0 byte_data[6:0] < MUX_MIN |=> $stable(mux_ratio))
      else $error("low mux ratio taken");
   enh_reserved_a: assert property (take(CMD_ENHANCE_B) ##0 byte_data[5:4] == ENH_B_RESERVED |=> $stable(enhance_b_mode))
      else $error("reserved mode taken");
   lock_write_a: assert property (take(CMD_LOCK) |=> locked == $past(lock_bit))
      else $error("lock bit not followed");
   locked_freeze_a: assert property (locked |=> $stable(cfg[18:2]))
      else $error("setting moved while locked");
   mem_follow_a: assert property (!$past(reset) |-> memory_access_ok == !$past(locked))
      else $error("memory access flag wrong");
   linear_load_a: assert property (acc && !data_select && byte_data == CMD_GRAY_LINEAR && !locked |-> ##2 gray_level_widths == LIN)
      else $error("linear table wrong");
endmodule
bind dcd_decoder dcd_checker u_dcd_checker (.*);

// ### test/dcd_host.sv
/* host model: writes bytes to the decoder.
   assumes calls start just after a core_clk edge. */
`timescale 1ns/1ns
module dcd_host (
   input wire logic  core_clk,
   output logic       chip_select_n,
   output logic       data_select,
   output logic       byte_strobe,
   output logic [7:0] byte_data
);
   // bus idle at time zero
   initial begin
      chip_select_n = 1'b1;
      data_select = 1'b0;
      byte_strobe = 1'b0;
      byte_data = 8'h00;
   end
   // one byte held for one edge
   task put(input logic cs_n, input logic dc, input logic [7:0] b);
      chip_select_n = cs_n;
      data_select = dc;
      byte_data = b;
      byte_strobe = 1'b1;
      @(posedge core_clk);
      #1;
   endtask
   // release: data shows the inverse of the last byte
   task idle;
      byte_strobe = 1'b0;
      chip_select_n = 1'b1;
      byte_data = ~byte_data;
      @(posedge core_clk);
      #1;
   endtask
endmodule

// ### test/tb_display_config_command_decoder.sv
/* testbench of the command decoder.
   assumes the host model and the bound checker. */
`timescale 1ns/1ns
module tb_display_config_command_decoder;
   import dcd_pkg::*;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic chip_select_n, data_select, byte_strobe, gray_custom_active, memory_access_ok;
   logic [7:0] byte_data;
   logic [29:0] snap, e;
   logic [127:0] gray_level_widths, g;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   localparam logic [29:0] RST = {PRECHARGE_RESET, DESELECT_RESET, CONTRAST_RESET,
      MASTER_RESET, MUX_RESET, ENH_B_RESET, 1'b0};
   localparam logic [127:0] LIN = 128'h70686058_50484038_30282018_10080000;
   // clock and instances
   always #5 core_clk = ~core_clk;
   dcd_host u_dcd_host (.*);
   dcd_decoder u_dcd_decoder (.*, .precharge_level(snap[29:25]),
      .common_deselect_level(snap[24:22]), .segment_current(snap[21:14]),
      .master_current(snap[13:10]), .mux_ratio(snap[9:3]), .enhance_b_mode(snap[2:1]),
      .locked(snap[0]));
   // bus tasks and comparison
   task cmp(input logic [127:0] got, input logic [127:0] want);
      checks++;
      if (got !== want) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   task chk(input logic [29:0] x);
      e = x;
      cmp(snap, e);
   endtask
   task cmd(input logic [7:0] b);
      u_dcd_host.put(1'b0, 1'b0, b);
   endtask
   task par(input logic [7:0] b);
      u_dcd_host.put(1'b0, 1'b1, b);
   endtask
   task wr(input logic [7:0] c, input logic [7:0] p, input logic [29:0] x);
      cmd(c);
      par(p);
      u_dcd_host.idle;
      chk(x);
   endtask
   task tally_and_finish;
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // cycle ceiling
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 1000) begin
         bad_count++;
         tally_and_finish;
      end
   end
   // main sequence
   initial begin
      e = RST;
      g = '0;
      repeat (3) @(posedge core_clk);
      #1;
      reset = 1'b0;
      u_dcd_host.idle;
      chk(RST);
      cmp(gray_level_widths, LIN);
      wr(8'hBB, 8'hFF, {5'h1F, e[24:0]});
      wr(8'hBE, 8'hFF, {e[29:25], 3'h7, e[21:0]});
      wr(8'hC7, 8'hF3, {e[29:14], 4'h3, e[9:0]});
      wr(8'hCA, 8'h0E, e);
      wr(8'hCA, 8'h8F, {e[29:10], 7'h0F, e[2:0]});
      cmd(8'hD1);
      par(8'h02);
      par(8'h20);
      u_dcd_host.idle;
      chk(e);
      cmd(8'hD1);
      par(8'h12);
      par(8'h20);
      u_dcd_host.idle;
      chk({e[29:3], 2'h1, e[0]});
      cmd(8'hB8);
      par(8'h01);
      wr(8'hC1, 8'h33, {e[29:22], 8'h33, e[13:0]});
      u_dcd_host.put(1'b1, 1'b0, 8'hC1);
      u_dcd_host.put(1'b1, 1'b1, 8'h22);
      u_dcd_host.idle;
      chk(e);
      cmd(8'hB8);
      for (int i = 1; i < 16; i++) begin
         g[8*i +: 8] = 8'(i * 16);
         par(8'(i * 16));
      end
      u_dcd_host.idle;
      u_dcd_host.idle;
      cmp(gray_level_widths, LIN);
      cmd(8'h00);
      u_dcd_host.idle;
      u_dcd_host.idle;
      cmp(gray_level_widths, g);
      cmp(gray_custom_active, 1'b1);
      cmd(8'hB9);
      u_dcd_host.idle;
      u_dcd_host.idle;
      cmp(gray_level_widths, LIN);
      cmp(gray_custom_active, 1'b0);
      wr(8'hFD, 8'h16, {e[29:1], 1'b1});
      wr(8'hC1, 8'h11, e);
      cmp(memory_access_ok, 1'b0);
      wr(8'hFD, 8'h12, {e[29:1], 1'b0});
      wr(8'hFD, 8'h16, {e[29:1], 1'b1});
      reset = 1'b1;
      u_dcd_host.idle;
      reset = 1'b0;
      u_dcd_host.idle;
      chk(RST);
      cmp(gray_level_widths, LIN);
      tally_and_finish;
   end
endmodule
